// ===== hw/nhs_top.sv
// Oscillator hop control, input select and sample qualification with FIFO.
// Assumes pins arrive asynchronous to aclk and an AXI4-Lite master.
//
// Added by the designer: the AXI4-Lite interface to the registers.
`include "nhs_cfg.svh"
`timescale 1ns/100ps
`default_nettype none

module nhs_fifo #(
  parameter int WIDTH = 34,
  parameter int DEPTH = 8
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic      [WIDTH-1:0] out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_r;
  logic [AW-1:0]    rd_r;
  logic [AW:0]      cnt_r;
  logic             push;
  logic             pop;

  assign in_ready  = (cnt_r != DEPTH[AW:0]);
  assign out_valid = (cnt_r != '0);
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  assign out_data  = mem[rd_r];

  always_ff @(posedge aclk) begin
    if (push) begin
      mem[wr_r] <= in_data;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_r  <= '0;
      rd_r  <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wr_r <= (wr_r == AW'(DEPTH - 1)) ? '0 : wr_r + 1'b1;
      end
      if (pop) begin
        rd_r <= (rd_r == AW'(DEPTH - 1)) ? '0 : rd_r + 1'b1;
      end
      cnt_r <= cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end
endmodule : nhs_fifo

module nhs_top #(
  parameter int FIFO_DEPTH = `NHS_FIFO_DEPTH
) (
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic [`NHS_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic      [1:0]            s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [`NHS_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic      [31:0]           s_axi_rdata,
  output logic      [1:0]            s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  input  wire logic [3:0]            sync_pin,
  input  wire logic [13:0]           input_mantissa_bus_a,
  input  wire logic [2:0]            input_exponent_bus_a,
  input  wire logic                  sample_qualifier_pin_a,
  input  wire logic [13:0]           input_mantissa_bus_b,
  input  wire logic [2:0]            input_exponent_bus_b,
  input  wire logic                  sample_qualifier_pin_b,
  output logic      [16:0]           i_path_data,
  output logic      [16:0]           q_path_data,
  output logic                       sample_valid,
  input  wire logic                  sample_ready,
  output logic      [31:0]           phase_acc,
  output logic      [15:0]           phase_offset,
  output logic                       amp_dither_en,
  output logic                       phase_dither_en
);
  // ****************************************************************
  // Pin synchronisers.
  // ****************************************************************
  localparam int PW = 4 + 2 * 18;
  logic [PW-1:0] pin_s1_r;
  logic [PW-1:0] pin_s2_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_s1_r <= '0;
      pin_s2_r <= '0;
    end else begin
      pin_s1_r <= {sync_pin, sample_qualifier_pin_a, input_exponent_bus_a,
                   input_mantissa_bus_a, sample_qualifier_pin_b,
                   input_exponent_bus_b, input_mantissa_bus_b};
      pin_s2_r <= pin_s1_r;
    end
  end
  logic [3:0]  sync_s;
  logic [16:0] word_a;
  logic [16:0] word_b;
  logic        en_a;
  logic        en_b;
  assign {sync_s, en_a, word_a, en_b, word_b} = pin_s2_r;

  // ****************************************************************
  // Register bus.
  // ****************************************************************
  logic [15:0] holdoff_r;
  logic [15:0] freq_lo_r;
  logic [15:0] freq_hi_r;
  logic [15:0] phase_r;
  logic [8:0]  ctrl_r;
  logic        sleep_r;
  logic [2:0]  pin_sync_r;
  logic [31:0] freq_work_r;
  logic [15:0] count_r;
  logic        counting_r;
  logic        aw_hold_r;
  logic        w_hold_r;
  logic [`NHS_ADDR_W-1:0] awaddr_r;
  logic [31:0] wdata_r;
  logic        wr_go;
  logic [7:0]  wr_idx;
  logic [7:0]  rd_idx;
  logic        wr_ok;
  logic        soft_hop;

  assign s_axi_awready = !aw_hold_r && !s_axi_bvalid;
  assign s_axi_wready  = !w_hold_r && !s_axi_bvalid;
  assign wr_go         = aw_hold_r && w_hold_r && !s_axi_bvalid;
  assign wr_idx        = awaddr_r[9:2];
  assign rd_idx        = s_axi_araddr[9:2];
  assign wr_ok         = (awaddr_r[`NHS_ADDR_W-1:10] == '0)
                         && (wr_idx >= `NHS_IDX_SLEEP)
                         && (wr_idx <= `NHS_IDX_STATUS);
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_r    <= 1'b0;
      w_hold_r     <= 1'b0;
      awaddr_r     <= '0;
      wdata_r      <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `NHS_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_r <= 1'b1;
        awaddr_r  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_r <= 1'b1;
        wdata_r  <= s_axi_wdata;
      end
      if (wr_go) begin
        aw_hold_r    <= 1'b0;
        w_hold_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? `NHS_RESP_OKAY : `NHS_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Byte strobes are ignored; the 16-bit registers take the whole low half, the others only their low bits.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      holdoff_r  <= '0;
      freq_lo_r  <= '0;
      freq_hi_r  <= '0;
      phase_r    <= '0;
      ctrl_r     <= '0;
      sleep_r    <= 1'b1;
      pin_sync_r <= '0;
    end else if (wr_go) begin
      case (wr_idx)
        `NHS_IDX_SLEEP:     sleep_r    <= wdata_r[0];
        `NHS_IDX_PIN_SYNC:  pin_sync_r <= wdata_r[2:0];
        `NHS_IDX_HOLDOFF:   holdoff_r  <= wdata_r[15:0];
        `NHS_IDX_FREQ_LO:   freq_lo_r  <= wdata_r[15:0];
        `NHS_IDX_FREQ_HI:   freq_hi_r  <= wdata_r[15:0];
        `NHS_IDX_PHASE:     phase_r    <= wdata_r[15:0];
        `NHS_IDX_CTRL:      ctrl_r     <= wdata_r[8:0];
        default: ;
      endcase
    end
  end
  assign soft_hop = wr_go && (wr_idx == `NHS_IDX_SOFT_SYNC)
                    && wdata_r[`NHS_SOFT_HOP];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= `NHS_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= `NHS_RESP_OKAY;
      s_axi_rdata  <= '0;
      if (s_axi_araddr[`NHS_ADDR_W-1:10] != '0) begin
        s_axi_rresp <= `NHS_RESP_SLVERR;
      end else begin
        case (rd_idx)
          `NHS_IDX_SLEEP:     s_axi_rdata <= {31'h0, sleep_r};
          `NHS_IDX_SOFT_SYNC: s_axi_rdata <= '0;
          `NHS_IDX_PIN_SYNC:  s_axi_rdata <= {29'h0, pin_sync_r};
          `NHS_IDX_HOLDOFF:   s_axi_rdata <= {16'h0, holdoff_r};
          `NHS_IDX_FREQ_LO:   s_axi_rdata <= {16'h0, freq_lo_r};
          `NHS_IDX_FREQ_HI:   s_axi_rdata <= {16'h0, freq_hi_r};
          `NHS_IDX_PHASE:     s_axi_rdata <= {16'h0, phase_r};
          `NHS_IDX_CTRL:      s_axi_rdata <= {23'h0, ctrl_r};
          `NHS_IDX_STATUS:    s_axi_rdata <= {15'h0, counting_r, count_r};
          default:            s_axi_rresp <= `NHS_RESP_SLVERR;
        endcase
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ****************************************************************
  // Input select and sample qualification.
  // ****************************************************************
  nhs_pkg::nhs_mode_e mode;
  logic        sel_en;
  logic        en_d_r;
  logic        take;
  logic [16:0] sel_word;
  logic [16:0] i_word;
  logic [16:0] q_word;
  logic        fifo_ready;

  assign mode = nhs_pkg::nhs_mode_e'(
                  ctrl_r[`NHS_CTRL_MODE_HI:`NHS_CTRL_MODE_LO]);
  assign sel_en   = ctrl_r[`NHS_CTRL_PORT_B] ? en_b : en_a;
  assign sel_word = ctrl_r[`NHS_CTRL_PORT_B] ? word_b : word_a;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      en_d_r <= 1'b0;
    end else begin
      en_d_r <= sel_en;
    end
  end

  // A sample that finds the FIFO full is dropped; the stream cannot stall
  // the converters, so back-pressure only shows as lost samples.
  always_comb begin
    case (mode)
      nhs_pkg::NHS_MODE_MASK_LOW: take = 1'b1;
      nhs_pkg::NHS_MODE_ON_HIGH:  take = sel_en;
      nhs_pkg::NHS_MODE_RISE:     take = sel_en && !en_d_r;
      nhs_pkg::NHS_MODE_FALL:     take = !sel_en && en_d_r;
      default:                    take = 1'b0;
    endcase
  end

  always_comb begin
    i_word = sel_word;
    q_word = '0;
    if (mode == nhs_pkg::NHS_MODE_MASK_LOW && !sel_en) begin
      i_word = '0;
    end
    if (ctrl_r[`NHS_CTRL_BYPASS]) begin
      i_word = word_a;
      q_word = word_b;
    end
  end

  logic sample_go;
  assign sample_go = take && !sleep_r;

  nhs_fifo #(
    .WIDTH (34),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .in_data   ({i_word, q_word}),
    .in_valid  (sample_go),
    .in_ready  (fifo_ready),
    .out_data  ({i_path_data, q_path_data}),
    .out_valid (sample_valid),
    .out_ready (sample_ready)
  );

  // ****************************************************************
  // Hop scheduling and phase accumulator.
  // ****************************************************************
  logic [1:0] sync_sel;
  logic       sync_now;
  logic       sync_d_r;
  logic       pin_hop;
  logic       hop_evt;
  logic       hop_fire;
  logic       shadow_wr;
  logic       wake;
  logic       sleep_d_r;

  assign sync_sel = ctrl_r[`NHS_CTRL_SYNC_HI:`NHS_CTRL_SYNC_LO];
  assign sync_now = sync_s[sync_sel];
  assign pin_hop  = sync_now && !sync_d_r
                    && pin_sync_r[`NHS_PIN_HOP_EN];
  assign hop_evt  = soft_hop || pin_hop;
  assign shadow_wr = wr_go && (holdoff_r == `NHS_HOLD_ONE)
                     && ((wr_idx == `NHS_IDX_FREQ_LO)
                     || (wr_idx == `NHS_IDX_FREQ_HI));
  assign wake = sleep_d_r && !sleep_r;
  // Hold-off 1 fires at the sync itself; larger values fire on the sample that steps the count from 2 to 1.
  assign hop_fire = (hop_evt && holdoff_r == `NHS_HOLD_ONE)
                    || (counting_r && !hop_evt && sample_go
                        && count_r == 16'h0002);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync_d_r  <= 1'b0;
      sleep_d_r <= 1'b1;
    end else begin
      sync_d_r  <= sync_now;
      sleep_d_r <= sleep_r;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_r    <= '0;
      counting_r <= 1'b0;
    end else if (hop_evt) begin
      count_r    <= holdoff_r;
      counting_r <= (holdoff_r > `NHS_HOLD_ONE);
    end else if (counting_r && sample_go) begin
      count_r <= count_r - 16'h0001;
      if (count_r == 16'h0002) begin
        counting_r <= 1'b0;
      end
    end
  end

  // Phase-continuous unless the clear bit is set.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      freq_work_r <= '0;
      phase_acc   <= '0;
    end else begin
      if (hop_fire || wake) begin
        freq_work_r <= {freq_hi_r, freq_lo_r};
      end else if (shadow_wr) begin
        freq_work_r <= (wr_idx == `NHS_IDX_FREQ_LO)
                       ? {freq_hi_r, wdata_r[15:0]}
                       : {wdata_r[15:0], freq_lo_r};
      end
      if (hop_fire && ctrl_r[`NHS_CTRL_CLR_HOP]) begin
        phase_acc <= '0;
      end else if (sample_go) begin
        phase_acc <= phase_acc + freq_work_r;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phase_offset    <= '0;
      amp_dither_en   <= 1'b0;
      phase_dither_en <= 1'b0;
    end else begin
      phase_offset    <= phase_r;
      amp_dither_en   <= ctrl_r[`NHS_CTRL_AMP_DITH];
      phase_dither_en <= ctrl_r[`NHS_CTRL_PH_DITH];
    end
  end
endmodule : nhs_top
`default_nettype wire

// ===== hw/nhs_cfg.svh
// Register offsets, field positions and shared constants for the hop block.
// Assumes it is included by bare name from files under hw/.
`ifndef NHS_CFG_SVH
`define NHS_CFG_SVH
// Printed offsets are word indices; byte address is four times the index.
`define NHS_IDX_SLEEP      8'h80
`define NHS_IDX_SOFT_SYNC  8'h81
`define NHS_IDX_PIN_SYNC   8'h82
`define NHS_IDX_HOLDOFF    8'h84
`define NHS_IDX_FREQ_LO    8'h85
`define NHS_IDX_FREQ_HI    8'h86
`define NHS_IDX_PHASE      8'h87
`define NHS_IDX_CTRL       8'h88
`define NHS_IDX_STATUS     8'h89
`define NHS_ADDR_W         12
`define NHS_CTRL_SYNC_HI   8
`define NHS_CTRL_SYNC_LO   7
`define NHS_CTRL_PORT_B    6
`define NHS_CTRL_MODE_HI   5
`define NHS_CTRL_MODE_LO   4
`define NHS_CTRL_CLR_HOP   3
`define NHS_CTRL_AMP_DITH  2
`define NHS_CTRL_PH_DITH   1
`define NHS_CTRL_BYPASS    0
`define NHS_SOFT_HOP       1
`define NHS_SOFT_START     0
`define NHS_PIN_HOP_EN     1
`define NHS_PIN_START_EN   0
`define NHS_HOLD_ONE       16'h0001
`define NHS_HOLD_ZERO      16'h0000
`define NHS_RESP_OKAY      2'h0
`define NHS_RESP_SLVERR    2'h2
`define NHS_FIFO_DEPTH     8
`endif

// ===== hw/nhs_pkg.sv
// Types shared by the hop and input-select block.
// Assumes the configuration header is compiled alongside.
package nhs_pkg;
  typedef enum logic [1:0] {
    NHS_MODE_MASK_LOW,
    NHS_MODE_ON_HIGH,
    NHS_MODE_RISE,
    NHS_MODE_FALL
  } nhs_mode_e;
  typedef logic [15:0] nhs_half_t;
endpackage : nhs_pkg

// ===== tb/nhs_top_properties.sv
// Checker for the bus handshake, the stream hold and register-fed outputs.
// Assumes it is bound into nhs_top and sees only that module's ports.
`timescale 1ns/100ps
`default_nettype none
module nhs_top_props #(
  parameter int FIFO_DEPTH = 8
) (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        sample_valid,
  input wire logic        sample_ready,
  input wire logic [16:0] i_path_data,
  input wire logic [16:0] q_path_data,
  input wire logic [15:0] phase_offset,
  input wire logic        amp_dither_en,
  input wire logic        phase_dither_en
);
  // ******************
  // Write age
  // ******************
  // Register outputs may only move shortly after a write beat is taken.
  logic [2:0] wr_age_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) wr_age_r <= 3'h7;
    else if (s_axi_wvalid && s_axi_wready) wr_age_r <= 3'h0;
    else if (wr_age_r != 3'h7) wr_age_r <= wr_age_r + 3'h1;
  end
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  a_write_answer: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:2] s_axi_bvalid) else $error("write left unanswered");
  a_one_response: assert property (
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answered twice");
  a_aw_refused: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answering");
  a_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read left unanswered");
  a_ar_refused: assert property (
    s_axi_rvalid |-> !s_axi_arready) else $error("read taken twice");
  a_sample_holds: assert property (
    sample_valid && !sample_ready |=> sample_valid
    && $stable(i_path_data) && $stable(q_path_data))
    else $error("stalled sample changed");
  a_phase_by_write: assert property (
    $changed(phase_offset) |-> wr_age_r < 3'h4)
    else $error("phase offset moved without write");
  a_dither_by_write: assert property (
    $changed({amp_dither_en, phase_dither_en}) |-> wr_age_r < 3'h4)
    else $error("dither enable moved without write");
  cover property (sample_valid && !sample_ready);
  cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
  cover property ($changed(phase_offset));
endmodule : nhs_top_props

bind nhs_top nhs_top_props #(.FIFO_DEPTH(FIFO_DEPTH)) u_props (
  .aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rresp(s_axi_rresp),
  .sample_valid(sample_valid), .sample_ready(sample_ready),
  .i_path_data(i_path_data), .q_path_data(q_path_data),
  .phase_offset(phase_offset), .amp_dither_en(amp_dither_en),
  .phase_dither_en(phase_dither_en)
);
`default_nettype wire

// ===== tb/nhs_adc_model.sv
// Behavioural model of one converter port feeding the hop block.
// Assumes the bench sets the qualifier level; data move every clock.
`timescale 1ns/100ps
`default_nettype none
module nhs_adc_model #(
  parameter logic [2:0] EXP_CODE = 3'h1
) (
  input  wire logic        aclk,
  input  wire logic        en_cmd,
  output logic      [13:0] mantissa,
  output logic      [2:0]  exponent,
  output logic             qualifier
);
  // ******************
  // Data source
  // ******************
  // A counting mantissa changes every cycle, so a stale capture never
  // passes for a fresh one; the fixed exponent tells the ports apart.
  logic [13:0] count_r = 14'h0001;
  always @(posedge aclk) begin
    count_r <= count_r + 14'h0001;
  end
  assign mantissa  = count_r;
  assign exponent  = EXP_CODE;
  assign qualifier = en_cmd;
endmodule : nhs_adc_model
`default_nettype wire

// ===== tb/nco_hop_and_input_select_tb.sv
// Self-checking bench: registers, hops, sync pins, routing and the FIFO.
// Assumes the converter model in tb/ and a 100 MHz synchronous-reset clock.
`timescale 1ns/100ps
`default_nettype none
module nco_hop_and_input_select_tb;
  // ******************
  // Signals
  // ******************
  logic        aclk = 1'b0, aresetn = 1'b0, srdy = 1'b0;
  logic        awv = 1'b0, wv = 1'b0, arv = 1'b0, ena = 1'b0, enb = 1'b0;
  logic        brdy = 1'b1, rrdy = 1'b1;
  logic [3:0]  sync = 4'h0;
  logic [11:0] awa = 12'h000, ara = 12'h000;
  logic [31:0] wd = 32'h0, rd_d, pacc;
  logic        awr, wrdy, bv, arr, rv, sv, ampd, phd, qa, qb;
  logic [1:0]  br, rr;
  logic [16:0] idat, qdat;
  logic [15:0] poff;
  logic [13:0] ma, mb;
  logic [2:0]  ea, eb;
  int          err_count = 0, checked = 0, cyc = 0;
  nhs_adc_model #(.EXP_CODE(3'h1)) u_adc_a (.aclk(aclk), .en_cmd(ena),
    .mantissa(ma), .exponent(ea), .qualifier(qa));
  nhs_adc_model #(.EXP_CODE(3'h6)) u_adc_b (.aclk(aclk), .en_cmd(enb),
    .mantissa(mb), .exponent(eb), .qualifier(qb));
  nhs_top #(.FIFO_DEPTH(8)) dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
    .s_axi_wready(wrdy), .s_axi_bresp(br), .s_axi_bvalid(bv),
    .s_axi_bready(brdy), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rd_d), .s_axi_rresp(rr),
    .s_axi_rvalid(rv), .s_axi_rready(rrdy), .sync_pin(sync),
    .input_mantissa_bus_a(ma), .input_exponent_bus_a(ea),
    .sample_qualifier_pin_a(qa), .input_mantissa_bus_b(mb),
    .input_exponent_bus_b(eb), .sample_qualifier_pin_b(qb),
    .i_path_data(idat), .q_path_data(qdat), .sample_valid(sv),
    .sample_ready(srdy), .phase_acc(pacc), .phase_offset(poff),
    .amp_dither_en(ampd), .phase_dither_en(phd));
  always #5 aclk = ~aclk;
  // The whole run needs a few hundred cycles; this ceiling cuts a hang.
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      tally_and_finish();
    end
  end
  // ******************
  // Shared tasks
  // ******************
  task automatic tally_and_finish();
    if (err_count == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input string nm, input logic [31:0] e, g);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask : chk
  // Handshakes are judged mid-cycle, where ready is settled, and acted on
  // at the following rising edge.
  task automatic wr(input logic [7:0] ix, input logic [31:0] d);
    logic ha, hw, hb;
    awa <= {2'h0, ix, 2'h0};
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    do begin
      @(negedge aclk);
      ha = awv && awr;
      hw = wv && wrdy;
      hb = bv;
      @(posedge aclk);
      if (ha) awv <= 1'b0;
      if (hw) wv <= 1'b0;
    end while (!hb);
  endtask : wr
  task automatic rd(input logic [7:0] ix, output logic [31:0] d,
                    output logic [1:0] r);
    logic ha, hr;
    ara <= {2'h0, ix, 2'h0};
    arv <= 1'b1;
    do begin
      @(negedge aclk);
      ha = arv && arr;
      hr = rv;
      d = rd_d;
      r = rr;
      @(posedge aclk);
      if (ha) arv <= 1'b0;
    end while (!hr);
  endtask : rd
  task automatic delta(input string nm, input logic [31:0] e);
    logic [31:0] p;
    @(negedge aclk);
    p = pacc;
    @(negedge aclk);
    chk(nm, e, pacc - p);
    @(posedge aclk);
  endtask : delta
  task automatic pulse(input int n, input string nm, input logic [31:0] e);
    sync[n] <= 1'b1;
    repeat (4) @(posedge aclk);
    sync <= 4'h0;
    repeat (10) @(posedge aclk);
    delta(nm, e);
  endtask : pulse
  // ******************
  // Scenarios
  // ******************
  task automatic t_regs();
    logic [7:0]  ix [5] = '{8'h84, 8'h85, 8'h86, 8'h87, 8'h88};
    logic [31:0] ev [5] = '{32'ha5c3, 32'h1234, 32'h8765, 32'hbeef, 32'h1fc};
    logic [31:0] d;
    logic [1:0]  r;
    for (int i = 0; i < 5; i++) wr(ix[i], ev[i] | 32'hffff_0000);
    for (int i = 0; i < 5; i++) begin
      rd(ix[i], d, r);
      chk("readback", ev[i], d);
    end
    chk("phase offset", 32'hbeef, {16'h0, poff});
    chk("dither enables", 32'h2, {30'h0, ampd, phd});
    rd(8'h8a, d, r);
    chk("unmapped resp", 32'h2, {30'h0, r});
    wr(8'h8a, 32'h0);
    chk("unmapped bresp", 32'h2, {30'h0, br});
    wr(8'h87, 32'hbeef);
    chk("mapped bresp", 32'h0, {30'h0, br});
  endtask : t_regs
  task automatic t_hops();
    logic [31:0] d;
    logic [1:0]  r;
    wr(8'h84, 32'h0);
    wr(8'h85, 32'h100);
    wr(8'h86, 32'h0);
    wr(8'h88, 32'h0);
    wr(8'h80, 32'h0);
    delta("wake word", 32'h100);
    wr(8'h85, 32'h300);
    delta("shadowed word", 32'h100);
    wr(8'h81, 32'h2);
    repeat (8) @(posedge aclk);
    delta("hold-off zero", 32'h100);
    wr(8'h84, 32'h3);
    wr(8'h81, 32'h2);
    repeat (8) @(posedge aclk);
    delta("counted hop", 32'h300);
    rd(8'h89, d, r);
    chk("count at rest", 32'h1, d);
    wr(8'h84, 32'h1);
    wr(8'h85, 32'h500);
    repeat (2) @(posedge aclk);
    delta("direct write", 32'h500);
  endtask : t_hops
  task automatic t_pins();
    wr(8'h84, 32'h2);
    wr(8'h85, 32'h700);
    wr(8'h82, 32'h0);
    wr(8'h88, 32'h100);
    pulse(2, "hop disabled", 32'h500);
    wr(8'h82, 32'h2);
    pulse(1, "other pin", 32'h500);
    pulse(2, "pin hop", 32'h700);
  endtask : t_pins
  task automatic t_clear();
    wr(8'h88, 32'h8);
    wr(8'h84, 32'h1);
    wr(8'h86, 32'h1);
    wr(8'h85, 32'h0);
    wr(8'h81, 32'h2);
    repeat (3) @(posedge aclk);
    @(negedge aclk);
    chk("cleared low", 32'h0, {16'h0, pacc[15:0]});
    chk("cleared acc", 32'h1, {31'h0, pacc < 32'h10_0000});
  endtask : t_clear
  task automatic t_route();
    ena <= 1'b1;
    enb <= 1'b1;
    srdy <= 1'b1;
    wr(8'h88, 32'h0);
    repeat (10) @(negedge aclk);
    chk("port a", 32'h1, {29'h0, idat[16:14]});
    chk("q idle", 32'h0, {15'h0, qdat});
    wr(8'h88, 32'h40);
    repeat (10) @(negedge aclk);
    chk("port b", 32'h6, {29'h0, idat[16:14]});
    wr(8'h88, 32'h1);
    repeat (10) @(negedge aclk);
    chk("bypass i", 32'h1, {29'h0, idat[16:14]});
    chk("bypass q", 32'h6, {29'h0, qdat[16:14]});
    wr(8'h88, 32'h0);
    ena <= 1'b0;
    repeat (10) @(negedge aclk);
    chk("masked", 32'h0, {15'h0, idat});
    @(posedge aclk);
  endtask : t_route
  task automatic t_fifo();
    int n;
    n = 0;
    srdy <= 1'b0;
    repeat (20) @(posedge aclk);
    chk("fifo full", 32'h1, {31'h0, sv});
    wr(8'h88, 32'h10);
    repeat (6) @(posedge aclk);
    delta("mode 01 idle", 32'h0);
    srdy <= 1'b1;
    repeat (20) begin
      @(negedge aclk);
      if (sv === 1'b1) n++;
    end
    chk("drained words", 32'd8, 32'(n));
    @(posedge aclk);
  endtask : t_fifo
  task automatic t_edge(input logic [31:0] ctl, input logic idle,
                        input string nm);
    logic [31:0] p;
    ena <= idle;
    wr(8'h88, ctl);
    repeat (6) @(posedge aclk);
    delta(nm, 32'h0);
    @(negedge aclk);
    p = pacc;
    @(posedge aclk);
    ena <= ~idle;
    repeat (8) @(negedge aclk);
    chk(nm, 32'h1_0000, pacc - p);
  endtask : t_edge
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_regs();
    t_hops();
    t_pins();
    t_clear();
    t_route();
    t_fifo();
    t_edge(32'h20, 1'b0, "rise mode");
    t_edge(32'h30, 1'b1, "fall mode");
    tally_and_finish();
  end
endmodule : nco_hop_and_input_select_tb
`default_nettype wire
